/* hw/rhp_port.sv */
`timescale 1ns/1ns
`include "rhp_defs.svh"

module rhp_port #(
  parameter int RESET_CYCLES  = `RHP_RESET_CYCLES,
  parameter int RESYNC_CYCLES = `RHP_RESYNC_CYCLES,
  parameter int RESUME_CYCLES = `RHP_RESUME_CYCLES
) (
  input  wire logic              clk_sys,
  input  wire logic              arst_n,
  input  wire rhp_pkg::rhp_cmd_s cmd,
  input  wire logic              cmd_valid,
  input  wire rhp_pkg::rhp_line_s line,
  input  wire logic              fixed_device,
  input  wire logic              per_port_oc,
  input  wire logic              power_switching,
  input  wire logic              port_power_own,
  input  wire logic              global_on,
  input  wire logic              global_off,
  input  wire logic              bus_resume_state,
  input  wire logic              hub_reset_done,
  output rhp_pkg::rhp_word_t     status_word,
  output logic                   drive_reset,
  output logic                   drive_resume,
  output logic                   power_out
);

  rhp_pkg::rhp_state_e state_r, state_nxt;
  logic [31:0] cnt_r, cnt_nxt;
  logic attach_r, attach_nxt;
  logic en_r, en_nxt;
  logic susp_r, susp_nxt;
  logic rst_r, rst_nxt;
  logic pwr_r, pwr_nxt;
  logic oc_r, oc_nxt;
  logic c_conn_r, c_conn_nxt;
  logic c_en_r, c_en_nxt;
  logic c_res_r, c_res_nxt;
  logic c_oc_r, c_oc_nxt;
  logic c_rst_r, c_rst_nxt;

  logic conn_now, pwr_now, oc_now;
  logic rst_done, res_done, hw_dis;

  always_comb begin
    pwr_now  = power_switching ? pwr_r : 1'b1;
    // Unswitched ports are always powered, so attach must not wait for a power command
    conn_now = fixed_device | (line.attached & pwr_now);
    oc_now   = per_port_oc & line.overcurrent;
  end

  always_comb begin
    state_nxt  = state_r;
    cnt_nxt    = cnt_r;
    attach_nxt = conn_now;
    en_nxt     = en_r;
    susp_nxt   = susp_r;
    rst_nxt    = rst_r;
    pwr_nxt    = pwr_r;
    oc_nxt     = oc_now;
    c_conn_nxt = c_conn_r;
    c_en_nxt   = c_en_r;
    c_res_nxt  = c_res_r;
    c_oc_nxt   = c_oc_r;
    c_rst_nxt  = c_rst_r;
    rst_done   = 1'b0;
    res_done   = 1'b0;
    hw_dis     = 1'b0;

    // Software clears first, so hardware sets below win
    if (cmd_valid) begin
      if (cmd.clr_conn_chg) c_conn_nxt = 1'b0;
      if (cmd.clr_en_chg) c_en_nxt = 1'b0;
      if (cmd.clr_resume_chg) c_res_nxt = 1'b0;
      if (cmd.clr_oc_chg) c_oc_nxt = 1'b0;
      if (cmd.clr_reset_chg) c_rst_nxt = 1'b0;
    end

    // Timed reset and resume sequences
    case (state_r)
      rhp_pkg::RHP_RESETTING: begin
        if (cnt_r == 32'(RESET_CYCLES - 1)) begin
          state_nxt = rhp_pkg::RHP_IDLE;
          rst_done  = 1'b1;
        end else begin
          cnt_nxt = cnt_r + 32'd1;
        end
      end
      rhp_pkg::RHP_RESUMING: begin
        if (cnt_r == 32'(RESUME_CYCLES - 1)) begin
          state_nxt = rhp_pkg::RHP_EOP;
          cnt_nxt   = '0;
        end else begin
          cnt_nxt = cnt_r + 32'd1;
        end
      end
      rhp_pkg::RHP_EOP: begin
        // Low-speed end of packet lasts two clock cycles
        if (cnt_r == 32'd1) begin
          state_nxt = rhp_pkg::RHP_RESYNC;
          cnt_nxt   = '0;
        end else begin
          cnt_nxt = cnt_r + 32'd1;
        end
      end
      rhp_pkg::RHP_RESYNC: begin
        if (cnt_r == 32'(RESYNC_CYCLES - 1)) begin
          state_nxt = rhp_pkg::RHP_IDLE;
          res_done  = 1'b1;
        end else begin
          cnt_nxt = cnt_r + 32'd1;
        end
      end
      default: begin
        cnt_nxt = '0;
      end
    endcase

    if (cmd_valid) begin
      if (cmd.set_reset) begin
        if (!conn_now) c_conn_nxt = 1'b1;
        else if (!rst_r) begin
          rst_nxt   = 1'b1;
          state_nxt = rhp_pkg::RHP_RESETTING;
          cnt_nxt   = '0;
        end
      end
      if (cmd.set_enable) begin
        if (!conn_now) c_conn_nxt = 1'b1;
        else en_nxt = 1'b1;
      end
      if (cmd.clr_enable) en_nxt = 1'b0;
      if (cmd.set_suspend) begin
        if (!conn_now) c_conn_nxt = 1'b1;
        else susp_nxt = 1'b1;
      end
      if (cmd.resume && susp_r && state_r == rhp_pkg::RHP_IDLE) begin
        state_nxt = rhp_pkg::RHP_RESUMING;
        cnt_nxt   = '0;
      end
      if (port_power_own) begin
        if (cmd.set_power) pwr_nxt = 1'b1;
        if (cmd.clr_power) pwr_nxt = 1'b0;
      end
    end
    if (!port_power_own) begin
      if (global_on) pwr_nxt = 1'b1;
      if (global_off) pwr_nxt = 1'b0;
    end
    // Raw input: power drops even without per-port reporting
    if (line.overcurrent) pwr_nxt = 1'b0;

    if (rst_done) begin
      rst_nxt   = 1'b0;
      c_rst_nxt = 1'b1;
      en_nxt    = 1'b1;
      susp_nxt  = 1'b0;
      c_res_nxt = 1'b0;
    end
    if (res_done) begin
      susp_nxt  = 1'b0;
      c_res_nxt = 1'b1;
      en_nxt    = 1'b1;
    end
    if (bus_resume_state) susp_nxt = 1'b0;

    // Hardware disable causes
    if (en_r && (line.overcurrent || !conn_now || (power_switching && !pwr_nxt)
        || line.babble)) hw_dis = 1'b1;
    if (hw_dis) begin
      en_nxt   = 1'b0;
      c_en_nxt = 1'b1;
    end

    // Power off or unplug drops the port state
    if ((power_switching && !pwr_nxt) || !conn_now) begin
      susp_nxt  = 1'b0;
      rst_nxt   = 1'b0;
      en_nxt    = 1'b0;
      state_nxt = rhp_pkg::RHP_IDLE;
    end

    if (fixed_device) begin
      if (hub_reset_done) c_conn_nxt = 1'b1;
    end else if (conn_now != attach_r) begin
      c_conn_nxt = 1'b1;
    end
    if (oc_now != oc_r) c_oc_nxt = 1'b1;
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_r  <= rhp_pkg::RHP_IDLE;
      cnt_r    <= '0;
      attach_r <= 1'b0;
      en_r     <= 1'b0;
      susp_r   <= 1'b0;
      rst_r    <= 1'b0;
      pwr_r    <= 1'b0;
      oc_r     <= 1'b0;
      c_conn_r <= 1'b0;
      c_en_r   <= 1'b0;
      c_res_r  <= 1'b0;
      c_oc_r   <= 1'b0;
      c_rst_r  <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      cnt_r    <= cnt_nxt;
      attach_r <= attach_nxt;
      en_r     <= en_nxt;
      susp_r   <= susp_nxt;
      rst_r    <= rst_nxt;
      pwr_r    <= pwr_nxt;
      oc_r     <= oc_nxt;
      c_conn_r <= c_conn_nxt;
      c_en_r   <= c_en_nxt;
      c_res_r  <= c_res_nxt;
      c_oc_r   <= c_oc_nxt;
      c_rst_r  <= c_rst_nxt;
    end
  end

  always_comb begin
    status_word                      = `RHP_RESET_VALUE;
    status_word[`RHP_B_ATTACHED]     = attach_r;
    status_word[`RHP_B_ENABLED]      = en_r;
    status_word[`RHP_B_SUSPENDED]    = susp_r;
    status_word[`RHP_B_OVERCURRENT]  = oc_r;
    status_word[`RHP_B_RESET]        = rst_r;
    status_word[`RHP_B_POWER]        = power_switching ? pwr_r : 1'b1;
    status_word[`RHP_B_SLOW]         = attach_r & line.slow;
    status_word[`RHP_B_CONN_CHG]     = c_conn_r;
    status_word[`RHP_B_EN_CHG]       = c_en_r;
    status_word[`RHP_B_RESUME_CHG]   = c_res_r;
    status_word[`RHP_B_OC_CHG]       = c_oc_r & per_port_oc;
    status_word[`RHP_B_RESET_CHG]    = c_rst_r;
    drive_reset  = rst_r;
    drive_resume = (state_r == rhp_pkg::RHP_RESUMING);
    power_out    = pwr_now;
  end

endmodule

/* hw/rhp_root_ports.sv */
// Notes on behaviour
// - Connect change flag sets on attach or detach; writing one clears it.
// - Reset, enable or suspend on a detached port sets connect change instead.
// - Fixed device port sets connect change only after a hub reset.
// - Speed bit reads one for slow device, zero for full speed.
// - Writing one to speed bit position turns port power off.
// - Writing one to power bit position turns port power on.
// - Overcurrent clears port power.
// - Power scheme and per-port mask choose global or per-port commands.
// - Power off resets attach, enable, suspend and reset state.
// - Without power switching the power bit reads one.
// - Writing one to reset bit starts reset; clears when reset done sets.
// - Overcurrent bit follows the input when per-port reporting; otherwise zero.
// - Writing one to overcurrent bit resumes a suspended port only.
// - Suspend set by write; cleared by resume done, reset done, bus resume.
// - Hardware disables on overcurrent, unplug, power off, babble; sets enable change.
// - Enable bit write one enables, attach bit write one disables.
// - Enable sets when reset or resume completes.
// - Attach bit shows live attachment; of all writes, only power on and power off alter it.
// - Fixed device port always reads attached.
// - Reset done sets at the end of the ten millisecond reset.
// - Resume done sets after pulse, end of packet and three millisecond delay.
// - Port writes during a bus transaction wait until it finishes.
// - Enable change sets only by hardware disable; writing one clears it.
`timescale 1ns/1ns
`include "rhp_defs.svh"

module rhp_root_ports #(
  parameter int RESET_CYCLES  = `RHP_RESET_CYCLES,
  parameter int RESYNC_CYCLES = `RHP_RESYNC_CYCLES,
  parameter int RESUME_CYCLES = `RHP_RESUME_CYCLES
) (
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  input  wire logic [7:0]  reg_code,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [31:0] reg_wdata,
  output logic [31:0]      reg_rdata,
  output logic             reg_rvalid,
  input  wire logic [1:0]  pin_attached,
  input  wire logic [1:0]  pin_slow,
  input  wire logic [1:0]  pin_overcurrent,
  input  wire logic [1:0]  babble_seen,
  input  wire logic        transaction_busy,
  input  wire logic [2:0]  fixed_device_mask,
  input  wire logic [2:0]  per_port_power_mask,
  input  wire logic        power_switch_scheme,
  input  wire logic        power_switching,
  input  wire logic        per_port_oc,
  input  wire logic        all_ports_power_on_cmd,
  input  wire logic        all_ports_power_off_cmd,
  input  wire logic        bus_resume_state,
  input  wire logic        hub_reset_done,
  output logic [1:0]       port_reset_drive,
  output logic [1:0]       port_resume_drive,
  output logic [1:0]       port_power_out
);

  function automatic rhp_pkg::rhp_cmd_s decode_cmd(input logic [31:0] w);
    rhp_pkg::rhp_cmd_s c;
    c.clr_enable     = w[`RHP_B_ATTACHED];
    c.set_enable     = w[`RHP_B_ENABLED];
    c.set_suspend    = w[`RHP_B_SUSPENDED];
    c.resume         = w[`RHP_B_OVERCURRENT];
    c.set_reset      = w[`RHP_B_RESET];
    c.set_power      = w[`RHP_B_POWER];
    c.clr_power      = w[`RHP_B_SLOW];
    c.clr_conn_chg   = w[`RHP_B_CONN_CHG];
    c.clr_en_chg     = w[`RHP_B_EN_CHG];
    c.clr_resume_chg = w[`RHP_B_RESUME_CHG];
    c.clr_oc_chg     = w[`RHP_B_OC_CHG];
    c.clr_reset_chg  = w[`RHP_B_RESET_CHG];
    return c;
  endfunction

  // Pin synchronisers
  logic [7:0] sync1_r, sync1_nxt, sync2_r, sync2_nxt;
  // Held write waiting for a bus transaction to finish
  logic [1:0]          pend_r, pend_nxt;
  rhp_pkg::rhp_cmd_s   pcmd_r [2];
  rhp_pkg::rhp_cmd_s   pcmd_nxt [2];
  logic                gon_r, gon_nxt, goff_r, goff_nxt;
  logic [31:0]         rdata_r, rdata_nxt;
  logic                rvalid_r, rvalid_nxt;
  logic [1:0]          rdrv_r, rdrv_nxt, mdrv_r, mdrv_nxt, pwr_r, pwr_nxt;

  rhp_pkg::rhp_word_t  word [2];
  logic [1:0]          drv_rst, drv_res, pwr_o;
  logic [1:0]          fire;

  always_comb begin
    sync1_nxt = {pin_attached, pin_slow, pin_overcurrent, babble_seen};
    sync2_nxt = sync1_r;
  end

  always_comb begin
    pend_nxt = pend_r;
    pcmd_nxt = pcmd_r;
    // Global power commands are held too, so every write obeys the bus
    gon_nxt  = gon_r | all_ports_power_on_cmd;
    goff_nxt = goff_r | all_ports_power_off_cmd;
    fire = transaction_busy ? 2'b00 : pend_r;
    // Retire fired writes first, so a write arriving now stays held
    if (!transaction_busy) begin
      pend_nxt = 2'b00;
      if (gon_r) gon_nxt = all_ports_power_on_cmd;
      if (goff_r) goff_nxt = all_ports_power_off_cmd;
    end
    if (reg_wr && reg_code == `RHP_WR_PORT1) begin
      pend_nxt[0] = 1'b1;
      pcmd_nxt[0] = decode_cmd(reg_wdata & 32'h001F_031F);
    end else if (reg_wr && reg_code == `RHP_WR_PORT2) begin
      pend_nxt[1] = 1'b1;
      pcmd_nxt[1] = decode_cmd(reg_wdata & 32'h001F_031F);
    end
  end

  always_comb begin
    rvalid_nxt = reg_rd;
    rdata_nxt  = rdata_r;
    if (reg_rd) begin
      if (reg_code == `RHP_RD_PORT1) rdata_nxt = word[0];
      else if (reg_code == `RHP_RD_PORT2) rdata_nxt = word[1];
      else rdata_nxt = 32'h0000_0000;
    end
    rdrv_nxt = drv_rst;
    mdrv_nxt = drv_res;
    pwr_nxt  = pwr_o;
  end

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_port
      rhp_pkg::rhp_line_s ln;
      assign ln.attached    = sync2_r[6 + g];
      assign ln.slow        = sync2_r[4 + g];
      assign ln.overcurrent = sync2_r[2 + g];
      assign ln.babble      = sync2_r[g];
      rhp_port #(
        .RESET_CYCLES  (RESET_CYCLES),
        .RESYNC_CYCLES (RESYNC_CYCLES),
        .RESUME_CYCLES (RESUME_CYCLES)
      ) u_port (
        .clk_sys          (clk_sys),
        .arst_n           (arst_n),
        .cmd              (pcmd_r[g]),
        .cmd_valid        (fire[g]),
        .line             (ln),
        .fixed_device     (fixed_device_mask[g + 1]),
        .per_port_oc      (per_port_oc),
        .power_switching  (power_switching),
        .port_power_own   (power_switch_scheme & per_port_power_mask[g + 1]),
        .global_on        (gon_r & ~transaction_busy),
        .global_off       (goff_r & ~transaction_busy),
        .bus_resume_state (bus_resume_state),
        .hub_reset_done   (hub_reset_done),
        .status_word      (word[g]),
        .drive_reset      (drv_rst[g]),
        .drive_resume     (drv_res[g]),
        .power_out        (pwr_o[g])
      );
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sync1_r  <= 8'h00;
      sync2_r  <= 8'h00;
      pend_r   <= 2'b00;
      pcmd_r   <= '{default: '0};
      gon_r    <= 1'b0;
      goff_r   <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rvalid_r <= 1'b0;
      rdrv_r   <= 2'b00;
      mdrv_r   <= 2'b00;
      pwr_r    <= 2'b00;
    end else begin
      sync1_r  <= sync1_nxt;
      sync2_r  <= sync2_nxt;
      pend_r   <= pend_nxt;
      pcmd_r   <= pcmd_nxt;
      gon_r    <= gon_nxt;
      goff_r   <= goff_nxt;
      rdata_r  <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
      rdrv_r   <= rdrv_nxt;
      mdrv_r   <= mdrv_nxt;
      pwr_r    <= pwr_nxt;
    end
  end

  assign reg_rdata         = rdata_r;
  assign reg_rvalid        = rvalid_r;
  assign port_reset_drive  = rdrv_r;
  assign port_resume_drive = mdrv_r;
  assign port_power_out    = pwr_r;

endmodule

/* shared/rhp_defs.svh */
`ifndef RHP_DEFS_SVH
`define RHP_DEFS_SVH

// Register codes: read and write codes of the two port registers
`define RHP_RD_PORT1        8'h15
`define RHP_RD_PORT2        8'h16
`define RHP_WR_PORT1        8'h95
`define RHP_WR_PORT2        8'h96

// Field positions of the port status register
`define RHP_B_ATTACHED      0
`define RHP_B_ENABLED       1
`define RHP_B_SUSPENDED     2
`define RHP_B_OVERCURRENT   3
`define RHP_B_RESET         4
`define RHP_B_POWER         8
`define RHP_B_SLOW          9
`define RHP_B_CONN_CHG      16
`define RHP_B_EN_CHG        17
`define RHP_B_RESUME_CHG    18
`define RHP_B_OC_CHG        19
`define RHP_B_RESET_CHG     20

`define RHP_RESET_VALUE     32'h0000_0000

// Timing: 250 MHz clock
`define RHP_CLK_PERIOD_NS   4
`define RHP_RESET_MS        10
`define RHP_RESYNC_MS       3
`define RHP_RESUME_US       20
`define RHP_RESET_CYCLES    (`RHP_RESET_MS * 1000000 / `RHP_CLK_PERIOD_NS)
`define RHP_RESYNC_CYCLES   (`RHP_RESYNC_MS * 1000000 / `RHP_CLK_PERIOD_NS)
`define RHP_RESUME_CYCLES   (`RHP_RESUME_US * 1000 / `RHP_CLK_PERIOD_NS)

`endif

/* shared/rhp_pkg.sv */
package rhp_pkg;

  typedef enum logic [2:0] {
    RHP_IDLE,
    RHP_RESETTING,
    RHP_RESUMING,
    RHP_EOP,
    RHP_RESYNC
  } rhp_state_e;

  // Decoded one-bit commands of a port register write
  typedef struct packed {
    logic clr_enable;
    logic set_enable;
    logic set_suspend;
    logic resume;
    logic set_reset;
    logic set_power;
    logic clr_power;
    logic clr_conn_chg;
    logic clr_en_chg;
    logic clr_resume_chg;
    logic clr_oc_chg;
    logic clr_reset_chg;
  } rhp_cmd_s;

  // Live line condition of one port
  typedef struct packed {
    logic attached;
    logic slow;
    logic overcurrent;
    logic babble;
  } rhp_line_s;

  typedef logic [31:0] rhp_word_t;

endpackage

/* testbench/rhp_dev_model.sv */
`timescale 1ns/1ns
module rhp_dev_model (
  input  wire logic [1:0] plug,
  input  wire logic [1:0] slow_dev,
  input  wire logic [1:0] short_req,
  input  wire logic [1:0] babble_req,
  input  wire logic [1:0] port_power_out,
  output logic [1:0]      pin_attached,
  output logic [1:0]      pin_slow,
  output logic [1:0]      pin_overcurrent,
  output logic [1:0]      babble_seen
);
  assign pin_attached    = plug;
  // Empty socket: speed line sits at its pull-down
  assign pin_slow        = plug & slow_dev;
  assign pin_overcurrent = short_req;
  // An unpowered device cannot babble
  assign babble_seen     = babble_req & port_power_out;
endmodule

/* testbench/rhp_root_ports_assertions.sv */
`timescale 1ns/1ns
module rhp_root_ports_chk #(
  parameter int RESET_CYCLES  = 20,
  parameter int RESYNC_CYCLES = 10,
  parameter int RESUME_CYCLES = 5
) (
  input wire logic        clk_sys,
  input wire logic        arst_n,
  input wire logic [7:0]  reg_code,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  input wire logic        reg_rvalid,
  input wire logic [1:0]  pin_overcurrent,
  input wire logic        transaction_busy,
  input wire logic [2:0]  per_port_power_mask,
  input wire logic        power_switch_scheme,
  input wire logic        power_switching,
  input wire logic        per_port_oc,
  input wire logic        all_ports_power_off_cmd,
  input wire logic [1:0]  port_reset_drive,
  input wire logic [1:0]  port_resume_drive,
  input wire logic [1:0]  port_power_out
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  logic        rd_port;
  logic [31:0] rst_cnt_r;
  assign rd_port = reg_rd && (reg_code == 8'h15 || reg_code == 8'h16);
  // Bounds the reset pulse so a stuck timer cannot hide
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rst_cnt_r <= 32'h0;
    end else begin
      rst_cnt_r <= port_reset_drive[0] ? rst_cnt_r + 32'h1 : 32'h0;
    end
  end
  a_read_answers: assert property (rd_port |=> reg_rvalid)
    else $error("port read not answered");
  a_reserved_zero: assert property (rd_port |=> reg_rdata[31:21] == 11'h0
    && reg_rdata[15:10] == 6'h0 && reg_rdata[7:5] == 3'h0) else $error("reserved bit set");
  a_power_fixed_on: assert property (rd_port && !power_switching
    && !$past(power_switching, 4) |=> reg_rdata[8]) else $error("power bit low");
  a_oc_masked: assert property (rd_port && !per_port_oc && !$past(per_port_oc, 4)
    |=> !reg_rdata[3]) else $error("overcurrent bit not masked");
  a_oc_powers_off: assert property ($rose(pin_overcurrent[0]) && power_switching
    |-> ##[1:6] !port_power_out[0]) else $error("overcurrent kept power");
  a_port_power_on: assert property (reg_wr && reg_code == 8'h95 && reg_wdata[8]
    && !reg_wdata[9] && power_switching && power_switch_scheme && per_port_power_mask[1]
    && !transaction_busy && !pin_overcurrent[0] ##1 (!reg_wr && !transaction_busy) [*2]
    |-> ##[0:3] port_power_out[0]) else $error("per-port power on ignored");
  a_global_off: assert property (all_ports_power_off_cmd && power_switching
    && !power_switch_scheme |-> ##[1:4] port_power_out == 2'h0) else $error("global off ignored");
  a_reset_holds: assert property ($rose(port_reset_drive[0])
    |-> port_reset_drive[0] [*8]) else $error("reset pulse short");
  a_reset_bounded: assert property (port_reset_drive[0]
    |-> rst_cnt_r <= RESET_CYCLES + 2) else $error("reset pulse long");
  a_resume_pulse: assert property ($rose(port_resume_drive[0])
    |-> port_resume_drive[0] [*4]) else $error("resume pulse short");
  c_reset: cover property ($rose(port_reset_drive[0]));
  c_resume: cover property ($rose(port_resume_drive[1]));
  c_power_off: cover property ($fell(port_power_out[0]));
endmodule

bind rhp_root_ports rhp_root_ports_chk #(.RESET_CYCLES(RESET_CYCLES),
  .RESYNC_CYCLES(RESYNC_CYCLES), .RESUME_CYCLES(RESUME_CYCLES)) rhp_root_ports_chk_inst (
  .clk_sys, .arst_n, .reg_code, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid,
  .pin_overcurrent, .transaction_busy, .per_port_power_mask, .power_switch_scheme,
  .power_switching, .per_port_oc, .all_ports_power_off_cmd, .port_reset_drive,
  .port_resume_drive, .port_power_out);

/* testbench/tb_usb_root_hub_port_control.sv */
`timescale 1ns/1ns
module tb_usb_root_hub_port_control;
  localparam int RST_CYC = 20;
  localparam int SYNC_CYC = 10;
  localparam int RES_CYC = 5;
  logic        clk_sys = 1'b0;
  logic        arst_n = 1'b0;
  logic [7:0]  reg_code = 8'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata;
  logic        reg_rvalid;
  logic [1:0]  pin_attached, pin_slow, pin_overcurrent, babble_seen;
  logic [1:0]  plug = 2'h0, slow_dev = 2'h0, short_req = 2'h0, babble_req = 2'h0;
  logic        transaction_busy = 1'b0;
  logic [2:0]  fixed_device_mask = 3'h0;
  logic [2:0]  per_port_power_mask = 3'h6;
  logic        power_switch_scheme = 1'b1;
  logic        power_switching = 1'b1;
  logic        per_port_oc = 1'b1;
  logic        all_on = 1'b0;
  logic        all_off = 1'b0;
  logic        bus_resume_state = 1'b0;
  logic        hub_reset_done = 1'b0;
  logic [1:0]  port_reset_drive, port_resume_drive, port_power_out;
  logic [31:0] word;
  int          bad_count = 0;
  int          n_tests = 0;
  int          seed = 13;
  always #2 clk_sys = ~clk_sys;

  rhp_root_ports #(.RESET_CYCLES(RST_CYC), .RESYNC_CYCLES(SYNC_CYC), .RESUME_CYCLES(RES_CYC))
    rhp_root_ports_inst (.clk_sys, .arst_n, .reg_code, .reg_wr, .reg_rd, .reg_wdata,
    .reg_rdata, .reg_rvalid, .pin_attached, .pin_slow, .pin_overcurrent, .babble_seen,
    .transaction_busy, .fixed_device_mask, .per_port_power_mask, .power_switch_scheme,
    .power_switching, .per_port_oc, .all_ports_power_on_cmd(all_on),
    .all_ports_power_off_cmd(all_off), .bus_resume_state, .hub_reset_done,
    .port_reset_drive, .port_resume_drive, .port_power_out);
  rhp_dev_model rhp_dev_model_inst (.plug, .slow_dev, .short_req, .babble_req,
    .port_power_out, .pin_attached, .pin_slow, .pin_overcurrent, .babble_seen);

  task automatic stop_test;
    $display("Comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic wr(input logic [7:0] code, input logic [31:0] data);
    @(posedge clk_sys);
    reg_code <= code;
    reg_wdata <= data;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    tick(4);
  endtask
  task automatic look(input logic [7:0] code, input logic [31:0] m, input logic [31:0] e,
                      input string what);
    @(posedge clk_sys);
    reg_code <= code;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk("read valid", {31'h0, reg_rvalid}, 32'h1);
    word = reg_rdata;
    chk(what, word & m, e);
  endtask
  task automatic gpow(input logic on);
    @(posedge clk_sys);
    all_on <= on;
    all_off <= !on;
    @(posedge clk_sys);
    all_on <= 1'b0;
    all_off <= 1'b0;
    tick(4);
  endtask
  function automatic logic [31:0] exp_att(input logic s);
    return 32'h0001_0101 | {22'h0, s, 9'h0};
  endfunction

  task automatic port_walk(input logic q);
    logic [7:0]  rc;
    logic [7:0]  wc;
    logic        s;
    rc = 8'h15 + {7'h0, q};
    wc = 8'h95 + {7'h0, q};
    s = 1'($random(seed));
    look(rc, 32'hFFFF_FFFF, 32'h0, "reset value");
    wr(wc, 32'h100);
    look(rc, 32'h100, 32'h100, "power on");
    chk("power out", {30'h0, port_power_out}, 32'h1 << q);
    slow_dev[q] <= s;
    plug[q] <= 1'b1;
    tick(6);
    look(rc, 32'h0001_0301, exp_att(s), "attach");
    wr(wc, 32'h0001_0001);
    look(rc, 32'h0003_0003, 32'h1, "clear change");
    wr(wc, 32'h10);
    look(rc, 32'h10, 32'h10, "reset on");
    chk("reset drive", {30'h0, port_reset_drive}, 32'h1 << q);
    tick(RST_CYC + 8);
    look(rc, 32'h0010_0016, 32'h0010_0002, "reset done");
    wr(wc, 32'h0010_0004);
    look(rc, 32'h0014_0004, 32'h4, "suspend");
    wr(wc, 32'h8);
    tick(RES_CYC + SYNC_CYC + 12);
    look(rc, 32'h0004_0006, 32'h0004_0002, "resume done");
    wr(wc, 32'h0004_0008);
    #1;
    chk("resume drive", {30'h0, port_resume_drive}, 32'h0);
    wr(wc, 32'h4);
    bus_resume_state <= 1'b1;
    tick(4);
    bus_resume_state <= 1'b0;
    look(rc, 32'h4, 32'h0, "bus resume");
    wr(wc, 32'h2);
    transaction_busy <= 1'b1;
    wr(wc, 32'h1);
    look(rc, 32'h2, 32'h2, "held write");
    transaction_busy <= 1'b0;
    tick(4);
    look(rc, 32'h0002_0002, 32'h0, "disable");
    wr(wc, 32'h2);
    babble_req[q] <= 1'b1;
    tick(6);
    babble_req[q] <= 1'b0;
    look(rc, 32'h0002_0002, 32'h0002_0000, "babble");
    wr(wc, 32'h0002_0002);
    look(rc, 32'h0002_0002, 32'h2, "enable change clear");
    short_req[q] <= 1'b1;
    tick(6);
    look(rc, 32'h0002_011B, 32'h0002_0008, "overcurrent");
    short_req[q] <= 1'b0;
    tick(6);
    look(rc, 32'h8, 32'h0, "oc gone");
    wr(wc, 32'h0002_0100);
    plug[q] <= 1'b0;
    tick(6);
    look(rc, 32'h0001_0001, 32'h0001_0000, "unplug");
    wr(wc, 32'h0001_0000);
    wr(wc, 32'h16);
    look(rc, 32'h0001_0016, 32'h0001_0000, "detached cmd");
    wr(wc, 32'($random(seed)) & 32'hFFE0_FCE0);
    look(rc, 32'hFFE0_FCE0, 32'h0, "reserved");
    wr(wc, 32'h200);
    look(rc, 32'h100, 32'h0, "power off");
  endtask

  initial begin
    repeat (20) @(posedge clk_sys);
    arst_n <= 1'b1;
    tick(2);
    look(8'h17, 32'hFFFF_FFFF, 32'h0, "unmapped");
    for (int i = 0; i < 2; i++) begin
      port_walk(i[0]);
    end
    power_switch_scheme <= 1'b0;
    gpow(1'b1);
    look(8'h15, 32'h100, 32'h100, "global on 1");
    look(8'h16, 32'h100, 32'h100, "global on 2");
    wr(8'h95, 32'h200);
    look(8'h15, 32'h100, 32'h100, "port cmd ignored");
    gpow(1'b0);
    look(8'h16, 32'h100, 32'h0, "global off");
    per_port_power_mask <= 3'h2;
    power_switch_scheme <= 1'b1;
    gpow(1'b1);
    look(8'h15, 32'h100, 32'h0, "masked port");
    look(8'h16, 32'h100, 32'h100, "unmasked port");
    power_switching <= 1'b0;
    tick(6);
    look(8'h15, 32'h100, 32'h100, "no switching");
    wr(8'h95, 32'h0001_0000);
    fixed_device_mask <= 3'h2;
    tick(6);
    look(8'h15, 32'h0001_0001, 32'h1, "fixed device");
    hub_reset_done <= 1'b1;
    @(posedge clk_sys);
    hub_reset_done <= 1'b0;
    tick(4);
    look(8'h15, 32'h0001_0000, 32'h0001_0000, "hub reset");
    per_port_oc <= 1'b0;
    short_req[0] <= 1'b1;
    tick(6);
    look(8'h15, 32'h0008_0008, 32'h0, "oc not reported");
    short_req[0] <= 1'b0;
    stop_test;
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    bad_count++;
    stop_test;
  end
endmodule
